// ==== src/uar_receiver.sv ====
// asynchronous serial receiver with two-entry buffer and wishbone registers
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Function
// - complete flag mirrors buffer not empty
// - disabling receiver flushes the buffer
// - interrupt requested while flag and enable
// - error flags stored per buffer entry
// - writes to error flag bits ignored
// - error flags raise no interrupt
// - frame error from first stop bit
// - overrun on full buffer, held char, start
// - overrun cleared on successful transfer
// - parity error zero when checking off
// - parity enable bit, odd select bit
// - parity mismatch stored beside frame data
// - parity flag valid until data read
// - disable immediate, abandons reception, releases pin
// - sixteen or eight samples per bit
// - start vote samples 8-10 or 4-6
// - realign bit timing at every start
// - sample state counts per bit
// - two of three majority per bit
// - frame complete after first stop bit
// - next start right after stop vote
// - unused upper data bits read zero
// - ninth bit stored per entry
module uar_receiver #(
  parameter logic [11:0] BAUD_DIV = uar_pkg::BAUD_DEF
) (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  input  wire logic        global_irq_en_i,
  output logic             rx_override_o,
  output logic             rx_irq_o
);
  import uar_pkg::*;

  logic             ack_reg;
  logic [31:0]      rdat_reg;
  logic [7:0]       ctrl_b_reg;
  logic [7:0]       ctrl_c_reg;
  logic             dbl_reg;
  logic [11:0]      pre_reg;
  logic             tick;
  logic             sync1_reg;
  logic             sync2_reg;
  uar_state_e       state_reg;
  logic [3:0]       samp_reg;
  logic [3:0]       bit_reg;
  logic [2:0]       vote_reg;
  logic [11:0]      shift_reg;
  logic             held_reg;
  uar_entry_s       held_entry_reg;
  logic             dor_pend_reg;
  uar_entry_s       fifo_reg [FIFO_DEPTH];
  logic [1:0]       count_reg;
  logic             rd_ptr_reg;
  logic             wr_ptr_reg;

  logic             wb_req;
  logic             rd_data;
  logic             receiver_enable;
  logic             parity_enable_bit;
  logic             parity_odd_select;
  logic [3:0]       nbits;
  logic [3:0]       last_samp;
  logic             vote_bit;
  logic             vote_point;
  logic             start_ok;
  logic             frame_done;
  logic             push;
  logic             wr_ctrl;
  logic             rx_complete_flag;
  uar_entry_s       head;
  uar_entry_s       new_entry;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // data bit count from size field: 5..9
  function automatic logic [3:0] char_bits(input logic sz2, input logic [1:0] sz);
    char_bits = sz2 ? 4'h9 : (4'h5 + {2'b00, sz});
  endfunction

  assign receiver_enable   = ctrl_b_reg[CB_RXEN];
  assign parity_enable_bit = ctrl_c_reg[CC_UPM1];
  assign parity_odd_select = ctrl_c_reg[CC_UPM0];
  assign nbits = char_bits(ctrl_b_reg[CB_SZ2], {ctrl_c_reg[CC_SZ1], ctrl_c_reg[CC_SZ0]});
  // sample states per bit by speed
  assign last_samp = dbl_reg ? SAMP_DBL : SAMP_NORM;
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign rd_data  = wb_req & ~wb_we_i & (wb_adr_i == ADDR_DATA);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign rx_override_o = receiver_enable;
  assign head = fifo_reg[rd_ptr_reg];
  // flag follows occupancy, drops with the enable
  // gating keeps the request from outliving the enable by the flush cycle
  assign rx_complete_flag = (count_reg != 2'd0) && receiver_enable;
  // only complete flag drives the interrupt
  assign rx_irq_o = rx_complete_flag & ctrl_b_reg[CB_RXCIE] & global_irq_en_i;

  // two-stage synchroniser
  // reset to idle high so no false falling edge follows reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= rxd_i;
      sync2_reg <= sync1_reg;
    end
  end

  // sample tick prescaler; divider value plus one clocks per sample
  assign tick = (pre_reg == 12'h000);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_reg <= 12'h000;
    end else if (tick) begin
      // divider fixed at build time; no software baud register
      pre_reg <= BAUD_DIV;
    end else begin
      pre_reg <= pre_reg - 12'h001;
    end
  end

  // sample history for the centre vote
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vote_reg <= 3'b111;
    end else if (receiver_enable && tick) begin
      vote_reg <= {vote_reg[1:0], sync2_reg};
    end
  end

  // centre three samples voted
  // vote_reg[1:0] hold the two samples just before the current one
  assign vote_bit   = majority({vote_reg[1:0], sync2_reg});
  assign vote_point = (samp_reg == (last_samp >> 1) + 4'h2);
  // start accepted when the centre vote is low
  assign start_ok   = tick && (state_reg == UAR_START) && vote_point && !vote_bit;
  // stop bit sits after data and optional parity
  assign frame_done = tick && (state_reg == UAR_BITS) && vote_point
                      && (bit_reg == nbits + {3'b000, parity_enable_bit} + 4'h1);

  always_comb begin
    logic [8:0] d;
    logic       par;
    d = 9'h000;
    par = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) begin
        d[i] = shift_reg[i + 1];
        par  = par ^ shift_reg[i + 1];
      end
    end
    new_entry.data = d;
    new_entry.fe   = ~vote_bit;
    new_entry.dor  = 1'b0;
    new_entry.upe  = parity_enable_bit &
                     ((par ^ parity_odd_select) != shift_reg[nbits + 4'h1]);
  end

  // receiver state machine
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= UAR_IDLE;
      samp_reg  <= 4'h0;
      bit_reg   <= 4'h0;
      shift_reg <= 12'h000;
    end else if (!receiver_enable) begin
      state_reg <= UAR_IDLE;
    end else if (tick) begin
      case (state_reg)
        UAR_IDLE: begin
          if (!sync2_reg) begin
            // timing realigned at first low sample
            state_reg <= UAR_START;
            samp_reg  <= 4'h1;
          end
        end
        UAR_START: begin
          samp_reg <= samp_reg + 4'h1;
          if (samp_reg == (last_samp >> 1) + 4'h2) begin
            if (vote_bit) begin
              state_reg <= UAR_IDLE;
            end else begin
              state_reg <= UAR_BITS;
              bit_reg   <= 4'h1;
            end
          end
        end
        UAR_BITS: begin
          samp_reg <= (samp_reg == last_samp) ? 4'h0 : samp_reg + 4'h1;
          if (samp_reg == (last_samp >> 1) + 4'h2) begin
            shift_reg[bit_reg] <= vote_bit;
            // done at stop vote, hunt next edge
            if (frame_done) begin
              state_reg <= UAR_IDLE;
            end else begin
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= UAR_IDLE;
        end
      endcase
    end
  end

  // shift register holding stage and overrun detection
  // a frame finishing while the char still waits overwrites it
  assign push = held_reg && (count_reg != 2'd2);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held_reg       <= 1'b0;
      held_entry_reg <= '0;
      dor_pend_reg   <= 1'b0;
    end else if (!receiver_enable) begin
      held_reg     <= 1'b0;
      dor_pend_reg <= 1'b0;
    end else begin
      // full buffer, waiting char, accepted start
      // a rejected spike is no start bit, so it cannot flag a loss
      if (held_reg && !push && start_ok) begin
        dor_pend_reg <= 1'b1;
      end else if (push) begin
        dor_pend_reg <= 1'b0;
      end
      if (frame_done) begin
        held_reg       <= 1'b1;
        held_entry_reg <= new_entry;
      end else if (push) begin
        held_reg <= 1'b0;
      end
    end
  end

  // two-entry buffer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg  <= 2'd0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      fifo_reg[0] <= '0;
      fifo_reg[1] <= '0;
    end else if (!receiver_enable) begin
      count_reg  <= 2'd0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
    end else begin
      if (push) begin
        fifo_reg[wr_ptr_reg]     <= held_entry_reg;
        fifo_reg[wr_ptr_reg].dor <= dor_pend_reg;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (rd_data && rx_complete_flag) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, rd_data && rx_complete_flag};
    end
  end

  // wishbone slave: ack one cycle after the request is taken
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // control registers; only byte lane 0 carries bits
  assign wr_ctrl = wb_req && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_b_reg <= CTRL_B_RST;
      ctrl_c_reg <= CTRL_C_RST;
      dbl_reg    <= 1'b0;
    end else if (wr_ctrl) begin
      case (wb_adr_i)
        ADDR_STATUS: dbl_reg <= wb_dat_i[ST_U2X];
        ADDR_CTRL_B: ctrl_b_reg <= {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
        ADDR_CTRL_C: ctrl_c_reg <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // read data stands only in the ack cycle, zero otherwise
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ADDR_DATA:   rdat_reg <= {24'h000000, head.data[7:0] & {8{rx_complete_flag}}};
        ADDR_STATUS: rdat_reg <= {24'h000000, rx_complete_flag, 2'b00,
                                  head.fe & rx_complete_flag, head.dor & rx_complete_flag,
                                  head.upe & rx_complete_flag, dbl_reg, 1'b0};
        ADDR_CTRL_B: rdat_reg <= {24'h000000, ctrl_b_reg[7:2],
                                  head.data[8] & rx_complete_flag, ctrl_b_reg[0]};
        ADDR_CTRL_C: rdat_reg <= {24'h000000, ctrl_c_reg};
        default:     rdat_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdat_reg <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ==== src/uar_pkg.sv ====
// package for the asynchronous serial receiver: register map, fields, types
package uar_pkg;

  localparam logic [3:0] ADDR_DATA    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_CTRL_B  = 4'h8;
  localparam logic [3:0] ADDR_CTRL_C  = 4'hc;
  localparam logic [3:0] ADDR_BAUD    = 4'h0 + 4'h0 + 4'h0 + 4'h0;

  // status register bit positions
  localparam int ST_RXC  = 7;
  localparam int ST_FE   = 4;
  localparam int ST_DOR  = 3;
  localparam int ST_UPE  = 2;
  localparam int ST_U2X  = 1;
  // control b bit positions
  localparam int CB_RXCIE = 7;
  localparam int CB_RXEN  = 4;
  localparam int CB_SZ2   = 2;
  localparam int CB_RXB8  = 1;
  // control c bit positions
  localparam int CC_UPM1  = 5;
  localparam int CC_UPM0  = 4;
  localparam int CC_USBS  = 3;
  localparam int CC_SZ1   = 2;
  localparam int CC_SZ0   = 1;

  localparam logic [7:0]  CTRL_B_RST  = 8'h00;
  localparam logic [7:0]  CTRL_C_RST  = 8'h06;
  localparam logic [11:0] BAUD_RST    = 12'h000;
  localparam logic [11:0] BAUD_DEF    = 12'h000;

  localparam logic [3:0] SAMP_NORM   = 4'hf;
  localparam logic [3:0] SAMP_DBL    = 4'h7;
  localparam logic [3:0] VOTE_NORM   = 4'h7;
  localparam logic [3:0] VOTE_DBL    = 4'h3;
  localparam int         FIFO_DEPTH  = 2;

  typedef enum logic [1:0] {
    UAR_IDLE,
    UAR_START,
    UAR_BITS
  } uar_state_e;

  typedef struct packed {
    logic [8:0] data;
    logic       fe;
    logic       dor;
    logic       upe;
  } uar_entry_s;

endpackage

// ==== dv/uar_tx_model.sv ====
// remote serial transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none
module uar_tx_model (
  input  wire logic clk_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;

  // bits go out lsb first, v[0] being the start bit
  task automatic send(input logic [11:0] v, input int n, input int len);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= v[i];
      repeat (len) @(posedge clk_i);
    end
    // line idles high between frames
    rxd_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== dv/uar_receiver_asserts.sv ====
// port-level assertions for the serial receiver
`timescale 1ns/100ps
`default_nettype none
module uar_receiver_asserts #(
  parameter logic [11:0] BAUD_DIV = uar_pkg::BAUD_DEF
) (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rxd_i,
  input wire logic        global_irq_en_i,
  input wire logic        rx_override_o,
  input wire logic        rx_irq_o
);
  import uar_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  enable_follow_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == ADDR_CTRL_B
    && wb_sel_i[0] |=> rx_override_o == $past(wb_dat_i[CB_RXEN]))
    else $error("pin override not following enable");
  off_quiet_a: assert property (!rx_override_o |-> !rx_irq_o)
    else $error("request while receiver off");
  irq_global_a: assert property (!global_irq_en_i |-> !rx_irq_o)
    else $error("request without global allow");
  irq_flag_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_STATUS
    && !wb_dat_o[ST_RXC] |-> !$past(rx_irq_o)) else $error("request with empty buffer");
endmodule

bind uar_receiver uar_receiver_asserts #(.BAUD_DIV(BAUD_DIV)) i_uar_receiver_asserts (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
  .global_irq_en_i(global_irq_en_i), .rx_override_o(rx_override_o), .rx_irq_o(rx_irq_o));
`default_nettype wire

// ==== dv/test_uar_receiver.sv ====
// self-checking bench for the serial receiver
`timescale 1ns/100ps
`default_nettype none
module test_uar_receiver;
  import uar_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic        gie       = 1'b1;
  logic [3:0]  wb_adr    = 4'h0;
  logic [3:0]  wb_sel    = 4'h1;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack, rxd, ovr, irq;
  logic [10:0] q[$];
  int          err_count = 0, checks_done = 0, seed = 34405, k;

  uar_receiver i_uar_receiver (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .rxd_i(rxd),
    .global_irq_en_i(gie), .rx_override_o(ovr), .rx_irq_o(irq));
  uar_tx_model i_uar_tx_model (.clk_i(clk_sys_i), .rxd_o(rxd));

  initial forever #20 clk_sys_i = ~clk_sys_i;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys_i); while (wb_ack !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // model entry: {frame error, parity error, nine data bits}
  task automatic frame(input logic [8:0] d, input int nb, input logic pe, od, stp, bad,
                       input int len);
    logic [11:0] v;
    int          n;
    d = d & 9'((1 << nb) - 1);
    v = {2'b00, d, 1'b0};
    n = nb + 1;
    if (pe) begin
      v[n] = ^d ^ od ^ bad;
      n++;
    end
    v[n] = stp;
    i_uar_tx_model.send(v, n + 1, len);
    repeat (4) @(posedge clk_sys_i);
    q.push_back({~stp, pe & bad, d});
  endtask

  // status and ninth bit must be read before the data pops
  task automatic pop(input logic dor);
    logic [31:0] s, b;
    logic [10:0] e;
    wb(1'b0, ADDR_STATUS, 8'h00);
    s = rd;
    wb(1'b0, ADDR_CTRL_B, 8'h00);
    b = rd;
    wb(1'b0, ADDR_DATA, 8'h00);
    e = q.pop_front();
    chk({s[ST_RXC], s[ST_FE], s[ST_DOR], s[ST_UPE]}, {1'b1, e[10], dor, e[9]}); // flags
    chk(b[CB_RXB8], e[8]); // ninth bit
    chk(rd, {24'h0, e[7:0]}); // data
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    wb(1'b0, ADDR_CTRL_B, 8'h00);
    chk(rd, {24'h0, CTRL_B_RST});
    wb(1'b0, ADDR_CTRL_C, 8'h00);
    chk(rd, {24'h0, CTRL_C_RST});
    wb(1'b0, 4'h2, 8'h00);
    chk(rd, 32'h0);
    wb(1'b1, ADDR_CTRL_B, 8'h90);
    // third frame waits in the shift register, last one has a bad stop bit
    for (k = 0; k < 3; k++) frame(9'($random(seed)), 8, 1'b0, 1'b0, k != 2, 1'b0, 16);
    chk(ovr, 1'b1); // pin taken
    chk(irq, 1'b1); // request
    gie <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(irq, 1'b0); // masked
    gie <= 1'b1;
    for (k = 0; k < 3; k++) pop(1'b0);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk(rd[ST_RXC], 1'b0); // empty
    chk(irq, 1'b0); // cause gone
    for (k = 0; k < 4; k++) begin
      wb(1'b1, ADDR_CTRL_C, {3'b001, k[0], 4'h6});
      frame(9'($random(seed)), 8, 1'b1, k[0], 1'b1, k[1], 16);
      pop(1'b0);
    end
    wb(1'b1, ADDR_CTRL_C, 8'h06);
    // fourth frame arrives while full and third is held
    for (k = 0; k < 4; k++) frame(9'($random(seed)), 8, 1'b0, 1'b0, 1'b1, 1'b0, 16);
    pop(1'b0);
    pop(1'b0);
    q.delete(0);
    pop(1'b1);
    frame(9'($random(seed)), 8, 1'b0, 1'b0, 1'b1, 1'b0, 16);
    pop(1'b0);
    // software empties the buffer by reading data until the flag drops
    for (k = 0; k < 2; k++) frame(9'($random(seed)), 8, 1'b0, 1'b0, 1'b1, 1'b0, 16);
    k = 0;
    wb(1'b0, ADDR_STATUS, 8'h00);
    while (rd[ST_RXC] === 1'b1 && k < 4) begin
      wb(1'b0, ADDR_DATA, 8'h00);
      k++;
      wb(1'b0, ADDR_STATUS, 8'h00);
    end
    chk(k, 2); // reads to empty
    q.delete();
    // short low spike must not start a frame
    i_uar_tx_model.send(12'h000, 1, 3);
    repeat (40) @(posedge clk_sys_i);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk(rd[ST_RXC], 1'b0); // spike rejected
    wb(1'b1, ADDR_STATUS, 8'h1e);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk(rd, 32'h02); // error bits kept
    frame(9'($random(seed)), 8, 1'b0, 1'b0, 1'b1, 1'b0, 8);
    pop(1'b0);
    wb(1'b1, ADDR_STATUS, 8'h00);
    wb(1'b1, ADDR_CTRL_C, 8'h00);
    frame(9'($random(seed)), 5, 1'b0, 1'b0, 1'b1, 1'b0, 16);
    pop(1'b0);
    wb(1'b1, ADDR_CTRL_C, 8'h06);
    wb(1'b1, ADDR_CTRL_B, 8'h94);
    frame(9'($random(seed)), 9, 1'b0, 1'b0, 1'b1, 1'b0, 16);
    pop(1'b0);
    // a nine-bit character lands, then the disable flushes it
    frame(9'($random(seed)), 9, 1'b0, 1'b0, 1'b1, 1'b0, 16);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk(rd[ST_RXC], 1'b1); // character waiting
    wb(1'b1, ADDR_CTRL_B, 8'h00);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk(rd[ST_RXC], 1'b0); // flushed
    chk(ovr, 1'b0); // pin released
    q.delete();
    report_and_stop();
  end

  initial begin
    #(40 * 40000);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
